// ==== core/pss_ctrl.sv ====
`timescale 1ns/1ps
`include "pss_params.svh"

// Function
// - Address captured only when a strobe is low and all selects active.
// - Two lowest address bits load a 2-bit wraparound burst counter.
// - Byte lane selects write their own lanes only while byte write gate low.
// - Global write low writes all lanes, ignoring lane selects and gate.
// - Burst advance low during a burst steps the burst counter.
// - Chip select one high makes the processor strobe ignored.
// - Select needs select one low, select two high, select three low.
// - Chip selects are evaluated only on cycles that load an address.
// - Output enable low drives data pins; high tri-states them.
// - First read cycle after deselect keeps outputs tri-stated.
// - Processor strobe with select one low captures address and burst start.
// - Controller strobe captures address and loads the burst start.
// - With both strobes low and select one low only the processor strobe is honoured.
// - Burst order strap: low linear, high interleaved, static.
// - Read data appears one clock after its address was registered.
// - Sleep input freezes activity and keeps stored state.
module pss_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Address and strobes
    input wire logic [`PSS_ADDR_W-1:0] addr_in,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_advance_n,
    // Chip selects
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    // Write controls
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [`PSS_LANES-1:0] byte_lane_select_n,
    // Static and asynchronous controls
    input wire logic burst_order_strap,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // Data pins, lane k is bits 9k+8..9k with its parity bit on top
    input wire logic [`PSS_DATA_W-1:0] dq_in,
    output logic [`PSS_DATA_W-1:0] dq_out_q,
    output logic dq_oe,
    // Storage array side
    output logic [`PSS_ADDR_W-1:0] core_addr,
    output logic [`PSS_LANES-1:0] core_lane_we_q,
    output logic [`PSS_DATA_W-1:0] core_wdata_q,
    input wire logic [`PSS_DATA_W-1:0] core_rdata,
    // Status
    output pss_pkg::pss_state_e access_state_q,
    output logic sleep_active_q
);
    import pss_pkg::*;

    logic [`PSS_ADDR_W-1:`PSS_HI_LSB] addr_hi_q;
    pss_burst_t burst_low_q;
    logic strap_done_q;
    logic interleave_q;
    logic read_q;
    logic drive_ok_q;
    logic proc_take;
    logic ctrl_take;
    logic load;
    logic selected;
    logic load_sel;
    logic active_edge;
    logic step;
    logic write_now;
    logic [`PSS_LANES-1:0] lanes_d;

    // Strobe decode; sleep blocks every load, burst step and write
    always_comb begin
        proc_take = !sleep_request && !processor_address_strobe_n
            && !chip_select_one_n;
        ctrl_take = !sleep_request && !controller_address_strobe_n
            && !proc_take;
        load = proc_take || ctrl_take;
        selected = !chip_select_one_n && chip_select_two
            && !chip_select_three_n;
        load_sel = load && selected;
        active_edge = load_sel || (!sleep_request && !load
            && access_state_q != PSS_DESEL);
        step = !sleep_request && !load && access_state_q != PSS_DESEL
            && !burst_advance_n;
    end

    // Lane enables: global write overrides gate and lane selects
    always_comb begin
        if (!global_write_n) begin
            lanes_d = `PSS_ALL_LANES;
        end else if (!byte_write_gate_n) begin
            lanes_d = ~byte_lane_select_n;
        end else begin
            lanes_d = `PSS_NO_LANES;
        end
        write_now = active_edge && (lanes_d != `PSS_NO_LANES);
    end

    // Strap caught once after reset release; later changes are ignored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_q <= 1'b0;
            interleave_q <= 1'b1;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            interleave_q <= burst_order_strap;
        end
    end

    // Upper address register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_hi_q <= `PSS_HI_RST;
        end else if (load_sel) begin
            addr_hi_q <= addr_in[`PSS_ADDR_W-1:`PSS_HI_LSB];
        end
    end

    // Low address bits walk the burst sequence
    pss_burst_ctr u_burst (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .load(load_sel),
        .step(step),
        .interleave(interleave_q),
        .start(addr_in[`PSS_HI_LSB-1:0]),
        .burst_low_q(burst_low_q)
    );

    assign core_addr = {addr_hi_q, burst_low_q};

    // Access state; a load with an inactive select deselects the device
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            access_state_q <= PSS_DESEL;
        end else if (load && !selected) begin
            access_state_q <= PSS_DESEL;
        end else if (load || !sleep_request) begin
            case (access_state_q)
                PSS_DESEL: begin
                    if (load) begin
                        access_state_q <= PSS_FIRST;
                    end
                end
                PSS_FIRST: begin
                    access_state_q <= PSS_BURST;
                end
                PSS_BURST: begin
                    access_state_q <= PSS_BURST;
                end
                default: begin
                    access_state_q <= PSS_DESEL;
                end
            endcase
        end
    end

    // Write strobes and data to the array, taken at the same edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_lane_we_q <= `PSS_NO_LANES;
            core_wdata_q <= `PSS_DATA_RST;
        end else begin
            core_lane_we_q <= active_edge ? lanes_d : `PSS_NO_LANES;
            if (write_now) begin
                core_wdata_q <= dq_in;
            end
        end
    end

    // Read pipeline: one output register stage behind the address
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            read_q <= 1'b0;
            dq_out_q <= `PSS_DATA_RST;
        end else begin
            read_q <= active_edge && !write_now;
            if (read_q) begin
                dq_out_q <= core_rdata;
            end
        end
    end

    // Drive permission; read_q is still low at the edge that opens the first cycle, so that
    // cycle stays masked, and a deselect edge drops drive at once
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_ok_q <= 1'b0;
        end else begin
            drive_ok_q <= read_q && !sleep_request
                && !(load && !selected);
        end
    end

    // Sleep indication
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_active_q <= 1'b0;
        end else begin
            sleep_active_q <= sleep_request;
        end
    end

    // Output enable acts without the clock, so this one output is gated
    assign dq_oe = drive_ok_q && !output_enable_n;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_emerge;
        access_state_q == PSS_DESEL ##1 access_state_q == PSS_FIRST;
    endsequence

    a_proc_addr_take: assert property (
        proc_take && selected |=> core_addr == $past(addr_in))
        else $error("processor strobe did not capture address");
    a_ctrl_addr_take: assert property (
        ctrl_take && selected && processor_address_strobe_n
        |=> core_addr == $past(addr_in))
        else $error("controller strobe did not capture address");
    a_proc_ignored: assert property (
        chip_select_one_n && controller_address_strobe_n
        && access_state_q == PSS_DESEL |=> access_state_q == PSS_DESEL)
        else $error("processor strobe taken with select one high");
    a_deselect_load: assert property (
        load && !selected |=> access_state_q == PSS_DESEL && !dq_oe)
        else $error("inactive select did not deselect");
    a_global_write: assert property (
        active_edge && !global_write_n |=> core_lane_we_q == `PSS_ALL_LANES)
        else $error("global write missed lanes");
    a_byte_write: assert property (
        active_edge && global_write_n
        |=> core_lane_we_q == ($past(byte_write_gate_n) ? `PSS_NO_LANES
            : ~$past(byte_lane_select_n)))
        else $error("byte lane enables wrong");
    a_linear_step: assert property (
        step && !interleave_q |=> burst_low_q == $past(burst_low_q) + 2'h1)
        else $error("linear burst step wrong");
    a_burst_hold: assert property (
        !load && burst_advance_n |=> $stable(core_addr))
        else $error("burst address moved without advance");
    a_first_mask: assert property (
        s_emerge |-> !dq_oe)
        else $error("outputs driven in first cycle after deselect");
    a_oe_off: assert property (
        output_enable_n |-> !dq_oe)
        else $error("pins driven with output enable high");
    a_read_latency: assert property (
        read_q |=> dq_out_q == $past(core_rdata))
        else $error("read data not registered one cycle later");
    a_sleep_hold: assert property (
        sleep_request |=> $stable(core_addr) && core_lane_we_q == `PSS_NO_LANES)
        else $error("activity during sleep");

endmodule // pss_ctrl

// ==== common/pss_params.svh ====
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// Array geometry: 128K words of four 9-bit lanes
`define PSS_ADDR_W 17
`define PSS_DEPTH 131072
`define PSS_DATA_W 36
`define PSS_LANES 4
`define PSS_LANE_W 9

// Burst counter width and the slice of the address it covers
`define PSS_BURST_W 2
`define PSS_HI_LSB 2

// Lane write patterns
`define PSS_ALL_LANES 4'hf
`define PSS_NO_LANES 4'h0

// Reset values
`define PSS_BURST_RST 2'h0
`define PSS_HI_RST 15'h0000
`define PSS_DATA_RST 36'h0_0000_0000

`endif

// ==== common/pss_pkg.sv ====
package pss_pkg;

    // Access state, Gray coded along deselect -> first -> burst
    typedef enum logic [1:0] {
        PSS_DESEL = 2'b00,
        PSS_FIRST = 2'b01,
        PSS_BURST = 2'b11
    } pss_state_e;

    typedef logic [1:0] pss_burst_t;

endpackage

// ==== core/pss_burst_ctr.sv ====
`timescale 1ns/1ps
`include "pss_params.svh"

module pss_burst_ctr (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic interleave,
    input wire pss_pkg::pss_burst_t start,
    // Burst address low bits
    output pss_pkg::pss_burst_t burst_low_q
);
    import pss_pkg::*;

    pss_burst_t start_q;
    pss_burst_t cnt_q;
    pss_burst_t cnt_d;
    pss_burst_t low_d;

    // Next step count and the address it maps to
    always_comb begin
        cnt_d = cnt_q + 2'h1;
        if (interleave) begin
            low_d = start_q ^ cnt_d;
        end else begin
            low_d = start_q + cnt_d;
        end
    end

    // Start value and step count; wraps inside the 4-word block
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_q <= `PSS_BURST_RST;
            cnt_q <= `PSS_BURST_RST;
            burst_low_q <= `PSS_BURST_RST;
        end else if (load) begin
            start_q <= start;
            cnt_q <= `PSS_BURST_RST;
            burst_low_q <= start;
        end else if (step) begin
            cnt_q <= cnt_d;
            burst_low_q <= low_d;
        end
    end

endmodule // pss_burst_ctr

// ==== tb/pss_array_model.sv ====
`timescale 1ns/1ps
`include "pss_params.svh"

// Storage array stand-in: 64 words, lane writable, read combinationally
module pss_array_model (
    // Clock
    input wire logic core_clk,
    // Array port
    input wire logic [`PSS_ADDR_W-1:0] core_addr,
    input wire logic [`PSS_LANES-1:0] core_lane_we_q,
    input wire logic [`PSS_DATA_W-1:0] core_wdata_q,
    output logic [`PSS_DATA_W-1:0] core_rdata
);
    logic [`PSS_DATA_W-1:0] mem [64];
    // Unwritten words hold a pattern, so a stray read never looks like written data
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 36'(i) ^ 36'h5_5555_5555;
        end
    end
    // Lane writes land at the edge after the strobes were registered
    always @(posedge core_clk) begin
        for (int k = 0; k < `PSS_LANES; k++) begin
            if (core_lane_we_q[k]) begin
                mem[core_addr[5:0]][k*9 +: 9] <= core_wdata_q[k*9 +: 9];
            end
        end
    end
    assign core_rdata = mem[core_addr[5:0]];
endmodule // pss_array_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "pss_params.svh"

module tb;
    import pss_pkg::*;
    typedef struct {logic [7:0] ctl; logic [16:0] a; pss_state_e st; logic ld;} pss_row_s;
    logic core_clk = 0, rst_b = 0, strap = 0, oe_n = 0, sleep = 0;
    logic processor_address_strobe_n_n = 1, controller_address_strobe_n_n = 1, adv_n = 1, cs1_n = 0, cs2 = 1, cs3_n = 0, gw_n = 1, bwe_n = 1;
    logic [16:0] addr_in = '0, exp_a;
    logic [3:0] lanes_n = 4'hf, we_q;
    logic [35:0] dq_in = '0, dq_out_q, wdata_q, rdata;
    logic dq_oe, sleep_q;
    logic [16:0] core_addr;
    pss_state_e state_q;
    int fails = 0, checks = 0;
    pss_row_s rows [9];

    always #5 core_clk = ~core_clk;

    pss_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b), .addr_in(addr_in),
        .processor_address_strobe_n(processor_address_strobe_n_n), .controller_address_strobe_n(controller_address_strobe_n_n),
        .burst_advance_n(adv_n), .chip_select_one_n(cs1_n), .chip_select_two(cs2),
        .chip_select_three_n(cs3_n), .global_write_n(gw_n), .byte_write_gate_n(bwe_n),
        .byte_lane_select_n(lanes_n), .burst_order_strap(strap), .output_enable_n(oe_n),
        .sleep_request(sleep), .dq_in(dq_in), .dq_out_q(dq_out_q), .dq_oe(dq_oe),
        .core_addr(core_addr), .core_lane_we_q(we_q), .core_wdata_q(wdata_q),
        .core_rdata(rdata), .access_state_q(state_q), .sleep_active_q(sleep_q));
    pss_array_model i_array (.core_clk(core_clk), .core_addr(core_addr),
        .core_lane_we_q(we_q), .core_wdata_q(wdata_q), .core_rdata(rdata));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Control byte: processor_address_strobe_n, controller_address_strobe_n, adv, cs1, cs2, cs3, gw, gate; applied off the sampling edge
    task automatic drive(input logic [7:0] c, input logic [16:0] a, input logic [3:0] ln,
                         input logic [35:0] d);
        @(negedge core_clk);
        {processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n, cs1_n, cs2, cs3_n, gw_n, bwe_n} = c;
        addr_in = a;
        lanes_n = ln;
        dq_in = d;
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset(input logic s);
        @(negedge core_clk);
        rst_b = 0;
        strap = s;
        sleep = 0;
        // Strobes idle, so the release edge starts no access
        {processor_address_strobe_n_n, controller_address_strobe_n_n, adv_n} = 3'b111;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1;
    endtask

    // Cut a hang short
    initial begin
        #500000;
        fails++;
        results();
    end

    initial begin
        rows = '{'{8'h6b, 17'h00101, PSS_FIRST, 1}, '{8'hab, 17'h00202, PSS_BURST, 1},
                 '{8'h7b, 17'h00303, PSS_BURST, 0}, '{8'h3b, 17'h00404, PSS_DESEL, 0},
                 '{8'ha3, 17'h00505, PSS_DESEL, 0}, '{8'haf, 17'h00606, PSS_DESEL, 0},
                 '{8'h7b, 17'h00909, PSS_DESEL, 0},
                 '{8'h2b, 17'h00707, PSS_FIRST, 1}, '{8'heb, 17'h00808, PSS_BURST, 0}};
        do_reset(0);
        #1;
        check(state_q, PSS_DESEL);
        check(dq_oe, 0);
        check(we_q, 4'h0);
        exp_a = '0;
        // Strobe and select combinations, address taken only on a selected load
        foreach (rows[i]) begin
            drive(rows[i].ctl, rows[i].a, 4'hf, '0);
            if (rows[i].ld) exp_a = rows[i].a;
            check(state_q, rows[i].st);
            check(core_addr, exp_a);
        end
        // Global write ignores lanes; byte write needs the gate
        drive(8'ha9, 17'h00005, 4'hf, 36'h9_8765_4321);
        check(we_q, 4'hf);
        check(wdata_q, 36'h9_8765_4321);
        drive(8'haa, 17'h00006, 4'ha, '0);
        check(we_q, 4'h5);
        drive(8'hab, 17'h00007, 4'h0, '0);
        check(we_q, 4'h0);
        // Read out of deselect: first cycle masked, data one edge later
        drive(8'ha3, 17'h00000, 4'hf, '0);
        check(dq_oe, 0);
        drive(8'h6b, 17'h00005, 4'hf, '0);
        check(dq_oe, 0);
        drive(8'hcb, 17'h00000, 4'hf, '0);
        check(dq_out_q, 36'h9_8765_4321);
        check(dq_oe, 1);
        check(core_addr, 17'h00006);
        @(negedge core_clk);
        oe_n = 1;
        #1;
        check(dq_oe, 0);
        oe_n = 0;
        // Sleep freezes loads and keeps state
        sleep = 1;
        drive(8'heb, 17'h00000, 4'hf, '0);
        drive(8'h6b, 17'h00011, 4'hf, '0);
        check(sleep_q, 1);
        check(core_addr, 17'h00006);
        check(state_q, PSS_BURST);
        // Both burst orders; select two dropped during advances must not deselect
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            drive(8'h6b, 17'h00011, 4'hf, '0);
            check(core_addr, 17'h00011);
            for (int n = 1; n <= 4; n++) begin
                drive(8'hc3, 17'h00000, 4'hf, '0);
                check(state_q, PSS_BURST);
                check(core_addr[1:0], s ? 2'(2'b01 ^ n[1:0]) : 2'(2'b01 + n[1:0]));
                check(core_addr[16:2], 15'h0004);
            end
        end
        results();
    end
endmodule // tb
